/* rtl/rpc_pin_ctrl.sv */
// Functional notes
// - MAC mode: output data-valid pin carries TX_EN toward the external PHY.
// - PHY mode: output data-valid pin carries CRS_DV toward the external MAC.
// - PHY mode with isolate set: output data-valid driver is tri-stated.
// - MAC mode speed follows pin with strap polarity; autoneg clear lets control bit override.
// - MAC mode duplex follows pin with strap polarity; autoneg clear lets control bit override.
// - PHY mode ignores speed and duplex input pins completely.
// - reference clock runs at 50 MHz and times all RMII data and valid pins.
// - clock-direction bit low makes reference clock an input, high an output.
// - MAC mode with reference clock as input enables its pull-down.
// - PHY mode, clock input and isolate clear: pull-down enabled.
// - reference clock as output: input buffer and pull-down disabled.
// - driven reference clock uses 12 mA when strength bit low, 16 mA when high.
// - PHY mode with isolate set: clock input buffer and pull-down disabled.
// - PHY mode with isolate set: clock output driver disabled regardless of direction.
// - mode straps, bit 0 among them, select switch port 0 operating mode.
// - straps sampled after reset release and at external reset release, then held.
`timescale 1ns/1ps
`default_nettype none

module rpc_pin_ctrl #(
  parameter logic [2:0] PHY_MODE_CODE = 3'h1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // software register port
  input wire logic [rpc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [rpc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [rpc_pkg::DATA_W-1:0] reg_rdata_o,
  // pins sampled in the core domain
  input wire logic port_speed_in_i,
  input wire logic port_duplex_in_i,
  input wire logic ext_rst_n_i,
  input wire logic port_mode_strap_bit0_i,
  input wire logic [2:1] port_mode_strap_hi_i,
  input wire logic speed_pol_strap_i,
  input wire logic duplex_pol_strap_i,
  // reference clock pin control
  output logic port_ref_clock_pin_oe_o,
  output logic port_ref_clock_pin_ibuf_en_o,
  output logic port_ref_clock_pin_pd_en_o,
  output logic port_ref_clock_pin_str16_o,
  // resolved port state for the switch core
  output logic phy_mode_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  // link side, timed by the 50 MHz reference clock
  input wire logic port_ref_clock_i,
  input wire logic link_valid_i,
  output logic port_out_data_valid_o,
  output logic port_out_data_valid_oe_o
);
  import rpc_pkg::*;

  // core domain
  typedef struct packed {
    rpc_ctrl_t ctrl;
    logic spd_s1;
    logic spd_s2;
    logic dpx_s1;
    logic dpx_s2;
    logic xrst_s1;
    logic xrst_s2;
    logic xrst_d;
    rpc_strap_t strap_s1;
    rpc_strap_t strap_s2;
    rpc_strap_t strap;
    logic [1:0] wait_cnt;
    logic phy;
    logic iso_phy;
    logic spd;
    logic dpx;
    rpc_refclk_t rc;
    logic [DATA_W-1:0] rdata;
  } rpc_core_t;

  rpc_core_t core_r;
  rpc_core_t core_nxt;
  rpc_bus_req_t req;
  rpc_strap_t strap_pins;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign strap_pins = '{mode: {port_mode_strap_hi_i, port_mode_strap_bit0_i},
                        spd_pol: speed_pol_strap_i, dpx_pol: duplex_pol_strap_i};

  always_comb begin
    logic pin_spd;
    logic pin_dpx;
    pin_spd = 1'b0;
    pin_dpx = 1'b0;
    core_nxt = core_r;

    // two-flop synchronisers for every asynchronous pin
    core_nxt.spd_s1 = port_speed_in_i;
    core_nxt.spd_s2 = core_r.spd_s1;
    core_nxt.dpx_s1 = port_duplex_in_i;
    core_nxt.dpx_s2 = core_r.dpx_s1;
    core_nxt.xrst_s1 = ext_rst_n_i;
    core_nxt.xrst_s2 = core_r.xrst_s1;
    core_nxt.xrst_d = core_r.xrst_s2;
    core_nxt.strap_s1 = strap_pins;
    core_nxt.strap_s2 = core_r.strap_s1;

    // wait for the strap pipeline to fill after release, then catch once;
    // a later external reset release catches again
    // the strap flops are held clear in reset, so the catch waits until they
    // carry pin levels; the counter parks one past the catch so it fires once
    if (core_r.wait_cnt != STRAP_WAIT + 2'h1) begin
      core_nxt.wait_cnt = core_r.wait_cnt + 2'h1;
    end
    if ((core_r.wait_cnt == STRAP_WAIT) || (core_r.xrst_s2 && !core_r.xrst_d)) begin
      core_nxt.strap = core_r.strap_s2;
    end

    core_nxt.phy = (core_r.strap.mode == PHY_MODE_CODE);
    core_nxt.iso_phy = core_r.phy && core_r.ctrl.iso;

    // live pins in MAC mode, overridden when auto-negotiation is off
    pin_spd = core_r.strap.spd_pol ? core_r.spd_s2 : !core_r.spd_s2;
    pin_dpx = core_r.strap.dpx_pol ? core_r.dpx_s2 : !core_r.dpx_s2;
    if (core_r.phy) begin
      // pins have no meaning here; control bits stand alone
      core_nxt.spd = core_r.ctrl.spd_sel;
      core_nxt.dpx = core_r.ctrl.dpx_sel;
    end else begin
      core_nxt.spd = core_r.ctrl.an ? pin_spd : core_r.ctrl.spd_sel;
      core_nxt.dpx = core_r.ctrl.an ? pin_dpx : core_r.ctrl.dpx_sel;
    end

    // reference clock pad control
    core_nxt.rc.oe = core_r.ctrl.clk_dir && !core_nxt.iso_phy;
    core_nxt.rc.ibuf_en = !core_r.ctrl.clk_dir && !core_nxt.iso_phy;
    core_nxt.rc.pd_en = !core_r.ctrl.clk_dir && !core_nxt.iso_phy;
    core_nxt.rc.str16 = core_r.ctrl.clk_str;

    // register port: write in the strobe cycle, read data in the next one only
    if (req.wr && req.addr == CTRL_OFS) begin
      core_nxt.ctrl.iso = req.wdata[CTRL_ISO_BIT];
      core_nxt.ctrl.an = req.wdata[CTRL_AN_BIT];
      core_nxt.ctrl.spd_sel = req.wdata[CTRL_SPD_BIT];
      core_nxt.ctrl.dpx_sel = req.wdata[CTRL_DPX_BIT];
      core_nxt.ctrl.clk_dir = req.wdata[CTRL_CDIR_BIT];
      core_nxt.ctrl.clk_str = req.wdata[CTRL_CSTR_BIT];
    end
    core_nxt.rdata = '0;
    if (req.rd) begin
      if (req.addr == CTRL_OFS) begin
        core_nxt.rdata[CTRL_ISO_BIT] = core_r.ctrl.iso;
        core_nxt.rdata[CTRL_AN_BIT] = core_r.ctrl.an;
        core_nxt.rdata[CTRL_SPD_BIT] = core_r.ctrl.spd_sel;
        core_nxt.rdata[CTRL_DPX_BIT] = core_r.ctrl.dpx_sel;
        core_nxt.rdata[CTRL_CDIR_BIT] = core_r.ctrl.clk_dir;
        core_nxt.rdata[CTRL_CSTR_BIT] = core_r.ctrl.clk_str;
      end else if (req.addr == STAT_OFS) begin
        core_nxt.rdata[STAT_PHY_BIT] = core_r.phy;
        core_nxt.rdata[STAT_SPD_BIT] = core_r.spd;
        core_nxt.rdata[STAT_DPX_BIT] = core_r.dpx;
        core_nxt.rdata[STAT_SPOL_BIT] = core_r.strap.spd_pol;
        core_nxt.rdata[STAT_DPOL_BIT] = core_r.strap.dpx_pol;
        core_nxt.rdata[STAT_MODE_LSB +: 3] = core_r.strap.mode;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      core_r <= '0;
      core_r.ctrl.iso <= CTRL_RST[CTRL_ISO_BIT];
      core_r.ctrl.an <= CTRL_RST[CTRL_AN_BIT];
      core_r.ctrl.spd_sel <= CTRL_RST[CTRL_SPD_BIT];
      core_r.ctrl.dpx_sel <= CTRL_RST[CTRL_DPX_BIT];
      core_r.ctrl.clk_dir <= CTRL_RST[CTRL_CDIR_BIT];
      core_r.ctrl.clk_str <= CTRL_RST[CTRL_CSTR_BIT];
      core_r.xrst_s1 <= 1'b1;
      core_r.xrst_s2 <= 1'b1;
      core_r.xrst_d <= 1'b1;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign reg_rdata_o = core_r.rdata;
  assign port_ref_clock_pin_oe_o = core_r.rc.oe;
  assign port_ref_clock_pin_ibuf_en_o = core_r.rc.ibuf_en;
  assign port_ref_clock_pin_pd_en_o = core_r.rc.pd_en;
  assign port_ref_clock_pin_str16_o = core_r.rc.str16;
  assign phy_mode_o = core_r.phy;
  assign speed_100_o = core_r.spd;
  assign full_duplex_o = core_r.dpx;

  // link domain (reference clock)
  // isolate and reset are levels; two flops each are enough. a few link
  // cycles of lag on isolate is harmless next to software timescales
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic iso_s1;
    logic iso_s2;
    logic dv;
    logic dv_oe;
  } rpc_link_t;

  rpc_link_t link_r;
  rpc_link_t link_nxt;

  always_comb begin
    link_nxt = link_r;
    link_nxt.rst_s1 = srst_i;
    link_nxt.rst_s2 = link_r.rst_s1;
    link_nxt.iso_s1 = core_r.iso_phy;
    link_nxt.iso_s2 = link_r.iso_s1;
    if (link_r.rst_s2) begin
      link_nxt.dv = 1'b0;
      link_nxt.dv_oe = 1'b0;
    end else begin
      // same pin is TX_EN in MAC mode and CRS_DV in PHY mode
      link_nxt.dv = link_valid_i;
      link_nxt.dv_oe = !link_r.iso_s2;
    end
  end

  always_ff @(posedge port_ref_clock_i) begin
    link_r <= link_nxt;
  end

  assign port_out_data_valid_o = link_r.dv;
  assign port_out_data_valid_oe_o = link_r.dv_oe;

endmodule : rpc_pin_ctrl

`default_nettype wire

/* rtl/rpc_pkg.sv */
package rpc_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;

  // control register field positions
  localparam int unsigned CTRL_ISO_BIT = 0;
  localparam int unsigned CTRL_AN_BIT = 1;
  localparam int unsigned CTRL_SPD_BIT = 2;
  localparam int unsigned CTRL_DPX_BIT = 3;
  localparam int unsigned CTRL_CDIR_BIT = 4;
  localparam int unsigned CTRL_CSTR_BIT = 5;

  // status register field positions
  localparam int unsigned STAT_PHY_BIT = 0;
  localparam int unsigned STAT_SPD_BIT = 1;
  localparam int unsigned STAT_DPX_BIT = 2;
  localparam int unsigned STAT_SPOL_BIT = 3;
  localparam int unsigned STAT_DPOL_BIT = 4;
  localparam int unsigned STAT_MODE_LSB = 5;

  // control reset value: auto-negotiation on, everything else clear
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h02;

  // reference clock figures
  localparam int unsigned REF_CLK_MHZ = 50;
  localparam int unsigned DRIVE_LOW_MA = 12;
  localparam int unsigned DRIVE_HIGH_MA = 16;

  // strap pipeline: cycles after reset release before straps are caught
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef struct packed {
    logic iso;
    logic an;
    logic spd_sel;
    logic dpx_sel;
    logic clk_dir;
    logic clk_str;
  } rpc_ctrl_t;

  typedef struct packed {
    logic [2:0] mode;
    logic spd_pol;
    logic dpx_pol;
  } rpc_strap_t;

  typedef struct packed {
    logic oe;
    logic ibuf_en;
    logic pd_en;
    logic str16;
  } rpc_refclk_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rpc_bus_req_t;

endpackage : rpc_pkg

/* tb/rpc_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module rpc_far_end (
  input wire logic drive_i,
  input wire logic spd_i,
  input wire logic dpx_i,
  output logic ref_clk_o,
  output logic spd_o,
  output logic dpx_o
);
  // reference clock runs free, phase offset from the core clock
  initial begin
    ref_clk_o = 1'b0;
    #1.3;
    forever #3 ref_clk_o = ~ref_clk_o;
  end
  // released indication pins float to their pull-up level
  assign spd_o = drive_i ? spd_i : 1'b1;
  assign dpx_o = drive_i ? dpx_i : 1'b1;
endmodule : rpc_far_end
`default_nettype wire

/* tb/rpc_pin_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rpc_pin_ctrl_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic port_ref_clock_pin_oe_o,
  input wire logic port_ref_clock_pin_ibuf_en_o,
  input wire logic port_ref_clock_pin_pd_en_o,
  input wire logic phy_mode_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o,
  input wire logic port_ref_clock_i,
  input wire logic link_valid_i,
  input wire logic port_out_data_valid_o,
  input wire logic port_out_data_valid_oe_o
);
  logic [2:0] cnt_r;
  logic [7:0] wr_r;
  logic [7:0] phy_r;
  // outputs lag reset release by a few cycles, so mode relations wait for this
  wire settled = cnt_r == 3'h7;
  always_ff @(posedge clk_i) begin
    cnt_r <= srst_i ? 3'h0 : cnt_r + {2'h0, !settled};
    wr_r <= {wr_r[6:0], reg_wr_i};
    phy_r <= {phy_r[6:0], phy_mode_o};
  end
  sequence s_ref_off;
    phy_mode_o && !port_ref_clock_pin_oe_o && !port_ref_clock_pin_ibuf_en_o;
  endsequence
  sequence s_ref_live;
    !phy_mode_o || port_ref_clock_pin_oe_o || port_ref_clock_pin_ibuf_en_o;
  endsequence
  a_out_no_input: assert property (@(posedge clk_i) disable iff (srst_i)
    port_ref_clock_pin_oe_o |-> !port_ref_clock_pin_ibuf_en_o && !port_ref_clock_pin_pd_en_o)
    else $error("ref clock driven with input path on");
  a_in_pulldown: assert property (@(posedge clk_i) disable iff (srst_i)
    !port_ref_clock_pin_oe_o |-> port_ref_clock_pin_ibuf_en_o == port_ref_clock_pin_pd_en_o)
    else $error("ref clock pull-down differs from input buffer");
  a_mac_pulldown: assert property (@(posedge clk_i) disable iff (srst_i)
    settled && !phy_mode_o && !port_ref_clock_pin_oe_o |-> port_ref_clock_pin_pd_en_o)
    else $error("mac input ref clock without pull-down");
  a_dir_select: assert property (@(posedge clk_i) disable iff (srst_i)
    settled ##0 s_ref_live |-> port_ref_clock_pin_oe_o != port_ref_clock_pin_ibuf_en_o)
    else $error("ref clock direction not exclusive");
  a_iso_dv_off: assert property (@(posedge clk_i) disable iff (srst_i)
    s_ref_off [*8] |-> !port_out_data_valid_oe_o)
    else $error("data-valid driven while isolated");
  a_dv_driven: assert property (@(posedge clk_i) disable iff (srst_i)
    settled ##0 s_ref_live [*8] |-> port_out_data_valid_oe_o)
    else $error("data-valid driver off while not isolated");
  a_phy_no_pin: assert property (@(posedge clk_i) disable iff (srst_i)
    &phy_r && $changed({speed_100_o, full_duplex_o}) |-> |wr_r)
    else $error("phy mode speed or duplex moved without a write");
  a_link_follow: assert property (@(posedge port_ref_clock_i) disable iff (srst_i)
    1'b1 |=> port_out_data_valid_o == $past(link_valid_i))
    else $error("data-valid pin does not follow link valid");
endmodule : rpc_pin_ctrl_chk
bind rpc_pin_ctrl rpc_pin_ctrl_chk u_rpc_pin_ctrl_chk (.clk_i, .srst_i, .reg_wr_i, .port_ref_clock_pin_oe_o,
  .port_ref_clock_pin_ibuf_en_o, .port_ref_clock_pin_pd_en_o, .phy_mode_o, .speed_100_o, .full_duplex_o,
  .port_ref_clock_i, .link_valid_i, .port_out_data_valid_o, .port_out_data_valid_oe_o);
`default_nettype wire

/* tb/test_rmii_port_pin_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rmii_port_pin_control;
  import rpc_pkg::*;
  logic clk = '0, srst = '1, wr = '0, rd = '0, spd = '0, dpx = '0, drv = '1, extn = '1, m0 = '0, spol = '0;
  logic dpol = '0, lv = '0, sp, dp, ps, pds, iso, o, i, es, ed;
  logic [1:0] mhi = '0;
  logic [2:0] md;
  logic [3:0] addr = '0;
  logic [7:0] wd = '0, rdata, rv, c;
  logic [31:0] r;
  logic oe, ib, pd, s16, phy, s100, fdx, dv, dvoe, rclk, spin, dpin;
  int seed = 32'h78f08603, err_count = 0, checks = 0;
  always #4 clk = ~clk;
  rpc_far_end u_rpc_far_end (.drive_i(drv), .spd_i(spd), .dpx_i(dpx), .ref_clk_o(rclk), .spd_o(spin), .dpx_o(dpin));
  rpc_pin_ctrl #(.PHY_MODE_CODE(3'h5)) u_rpc_pin_ctrl (.clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .port_speed_in_i(spin),
    .port_duplex_in_i(dpin), .ext_rst_n_i(extn), .port_mode_strap_bit0_i(m0), .port_mode_strap_hi_i(mhi),
    .speed_pol_strap_i(spol), .duplex_pol_strap_i(dpol), .port_ref_clock_pin_oe_o(oe),
    .port_ref_clock_pin_ibuf_en_o(ib), .port_ref_clock_pin_pd_en_o(pd), .port_ref_clock_pin_str16_o(s16),
    .phy_mode_o(phy), .speed_100_o(s100), .full_duplex_o(fdx), .port_ref_clock_i(rclk), .link_valid_i(lv),
    .port_out_data_valid_o(dv), .port_out_data_valid_oe_o(dvoe));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one access; read data is taken in the single cycle it stands
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, rd, addr, wd} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1 rv = rdata;
  endtask : acc
  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      md = ph[0] ? 3'h5 : 3'h2;
      {sp, dp} = 2'($random(seed));
      @(posedge clk);
      {mhi, m0, spol, dpol} <= {md, sp, dp};
      if (ph == 0) begin
        cyc(20);
        srst <= 1'b0;
      end else begin
        extn <= 1'b0;
        cyc(4);
        extn <= 1'b1;
      end
      cyc(8);
      // straps move after the catch and must not be seen
      {mhi, m0, spol, dpol} <= 5'($random(seed));
      if (ph == 0) begin
        acc(1'b0, CTRL_OFS, 8'h00);
        chk("ctrl_reset", rv, CTRL_RST);
      end
      repeat (16) begin
        r = $random(seed);
        c = {2'h0, r[13:8]};
        ps = r[0] ? r[1] : 1'b1;
        pds = r[0] ? r[2] : 1'b1;
        @(posedge clk);
        {dpx, spd, drv} <= r[2:0];
        acc(1'b1, CTRL_OFS, c);
        cyc(10);
        #1;
        iso = ph[0] & c[CTRL_ISO_BIT];
        o = c[CTRL_CDIR_BIT] & !iso;
        i = !c[CTRL_CDIR_BIT] & !iso;
        es = (!ph[0] && c[CTRL_AN_BIT]) ? (ps ~^ sp) : c[CTRL_SPD_BIT];
        ed = (!ph[0] && c[CTRL_AN_BIT]) ? (pds ~^ dp) : c[CTRL_DPX_BIT];
        chk("pins", {oe, ib, pd, phy, s100, fdx, dvoe}, {o, i, i, ph[0], es, ed, !iso});
        if (o) chk("str16", s16, c[CTRL_CSTR_BIT]);
        acc(1'b0, CTRL_OFS, 8'h00);
        chk("ctrl", rv, c);
        acc(1'b0, STAT_OFS, 8'h00);
        chk("status", rv, {md, dp, sp, ed, es, ph[0]});
        @(posedge rclk) lv <= r[20];
        @(posedge rclk) #1 chk("data_valid", dv, r[20]);
      end
      acc(1'b1, 4'hC, 8'hFF);
      acc(1'b1, STAT_OFS, 8'hFF);
      acc(1'b0, 4'hC, 8'h00);
      chk("unmapped", rv, 8'h00);
      acc(1'b0, STAT_OFS, 8'h00);
      chk("status_ro", rv & 8'hF9, {md, dp, sp, 2'h0, ph[0]});
      acc(1'b1, CTRL_OFS, CTRL_RST);
      cyc(10);
    end
    end_sim();
  end
endmodule : test_rmii_port_pin_control
`default_nettype wire
